// ---- shared/seq_pkg.sv ----
/*
  Shared constants and types of the program sequencer: address widths,
  return-stack size, instruction classes, stack entry and bus request carriers.
  Assumes a single ref_clk domain and a 32-bit APB register bus.
*/
package seq_pkg;

  localparam int ADDR_W = 12;
  localparam int STACK_LEVELS = 30;
  localparam int PTR_W = 5;
  localparam int COUNT_W = 16;

  localparam logic [ADDR_W-1:0] PC_RESET = 12'h000;
  localparam logic [ADDR_W-1:0] VECTOR_RESET = 12'h3FF;

  // Register byte offsets
  localparam logic [11:0] OFS_VECTOR = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_RESETS = 12'h008;

  // Status word field positions
  localparam int ST_PC_LSB = 0;
  localparam int ST_DEPTH_LSB = 12;
  localparam int ST_IE_BIT = 17;
  localparam int ST_CARRY_BIT = 18;
  localparam int ST_ZERO_BIT = 19;
  localparam int ST_BANK_BIT = 20;

  // Reset-event word field positions
  localparam int RS_COUNT_LSB = 0;
  localparam int RS_OVERFLOW_BIT = 16;
  localparam int RS_UNDERFLOW_BIT = 17;

  typedef enum logic [7:0] {
    OP_OTHER    = 8'h01,
    OP_JUMP     = 8'h02,
    OP_RETI_EN  = 8'h04,
    OP_RETI_DIS = 8'h08,
    OP_INT_EN   = 8'h10,
    OP_INT_DIS  = 8'h20,
    OP_BANK_A   = 8'h40,
    OP_BANK_B   = 8'h80
  } op_e;

  typedef struct packed {
    op_e op;
    logic [ADDR_W-1:0] target;
  } instr_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic carry;
    logic zero;
    logic bank;
  } stack_entry_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

endpackage

// ---- rtl/sync_2ff.sv ----
/*
  Two-stage synchroniser for asynchronous level inputs.
  Assumes the input is a level that stays stable for several ref_clk cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

// ---- rtl/return_stack.sv ----
/*
  Return stack of flip-flops: address, carry, zero and bank per level.
  Assumes the caller never pushes when full nor pops when empty.
*/
`timescale 1ns/1ns
`default_nettype none
module return_stack #(
  parameter int LEVELS = seq_pkg::STACK_LEVELS,
  parameter int PTR_W = seq_pkg::PTR_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic push,
  input wire logic pop,
  input wire seq_pkg::stack_entry_s push_data,
  output seq_pkg::stack_entry_s top_data,
  output logic full,
  output logic empty,
  output logic [PTR_W-1:0] depth
);
  import seq_pkg::*;

  stack_entry_s entry_reg [LEVELS];
  logic [PTR_W-1:0] depth_reg;
  logic [PTR_W-1:0] depth_next;
  logic [PTR_W-1:0] top_idx;

  assign full = (depth_reg == PTR_W'(LEVELS));
  assign empty = (depth_reg == '0);
  assign top_idx = empty ? '0 : depth_reg - PTR_W'(1);
  assign top_data = entry_reg[top_idx];
  assign depth = depth_reg;
  assign depth_next = clear ? '0 :
                      (push && !full) ? depth_reg + PTR_W'(1) :
                      (pop && !empty) ? depth_reg - PTR_W'(1) : depth_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      depth_reg <= '0;
    end else begin
      depth_reg <= depth_next;
    end
  end

  for (genvar i = 0; i < LEVELS; i++) begin : g_level
    always_ff @(posedge ref_clk) begin
      if (push && !full && !clear && depth_reg == PTR_W'(i)) begin
        entry_reg[i] <= push_data;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/program_sequencer.sv ----
/*
  Program-flow sequencer of a small 8-bit processor: program counter,
  unconditional jump, interrupt acceptance, interrupt return with enable or
  masked variants, return stack with self-reset on overflow and underflow,
  and an APB slave holding the interrupt vector, a status view and a
  self-reset event record.
  Assumes instructions arrive from program memory on ref_clk with instr_valid,
  and interrupt_request is an asynchronous level pin.
*/
// Design decisions made here: the APB interface to the registers and the register offsets.
// Overview of operation
// - Thirty nested stack levels, interrupts included.
// - Accepted interrupt consumes one stack level.
// - Interrupt push onto full stack self-resets.
// - Interrupt return from empty stack self-resets.
// - Enabling return ends routine, sets enable flag.
// - Masked return ends routine, enable stays clear.
// - Return restores bank active at interrupt.
// - Jump loads program counter with target.
// - Start at zero, then increment per instruction.
// - Jump changes only the program counter.
// - Jump target is twelve bits wide.
// - Self jump holds until reset or interrupt.
// - Interrupt pushes address, flags, bank; clears enable.
// - Interrupt return pops address and restores flags.
// - Interrupts disabled after reset.
`timescale 1ns/1ns
`default_nettype none
module program_sequencer #(
  parameter int LEVELS = seq_pkg::STACK_LEVELS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire seq_pkg::apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire seq_pkg::instr_s instr,
  input wire logic flag_update,
  input wire logic carry_result,
  input wire logic zero_result,
  input wire logic interrupt_request,
  output logic [seq_pkg::ADDR_W-1:0] program_counter,
  output logic interrupt_enable_flag,
  output logic carry_flag,
  output logic zero_flag,
  output logic bank_select,
  output logic interrupt_ack,
  output logic internal_reset
);
  import seq_pkg::*;

  function automatic logic op_is(input instr_s word, input op_e code);
    op_is = (word.op == code);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  logic [ADDR_W-1:0] pc_reg;
  logic [ADDR_W-1:0] pc_next;
  logic ie_reg;
  logic ie_next;
  logic carry_reg;
  logic carry_next;
  logic zero_reg;
  logic zero_next;
  logic bank_reg;
  logic bank_next;
  logic ack_reg;
  logic self_rst_reg;
  logic [ADDR_W-1:0] vector_reg;
  logic [ADDR_W-1:0] vector_next;
  logic [COUNT_W-1:0] rst_count_reg;
  logic [COUNT_W-1:0] rst_count_next;
  logic ovf_seen_reg;
  logic ovf_seen_next;
  logic unf_seen_reg;
  logic unf_seen_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pslverr_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt pin and return stack

  logic irq_sync;
  logic take_irq;
  logic exec;
  logic is_reti;
  logic is_jump;
  logic overflow;
  logic underflow;
  logic self_reset;
  logic stk_push;
  logic stk_pop;
  logic stk_full;
  logic stk_empty;
  logic [PTR_W-1:0] stk_depth;
  stack_entry_s stk_top;
  stack_entry_s stk_in;

  sync_2ff #(
    .WIDTH(1)
  ) u_irq_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(interrupt_request),
    .sync_out(irq_sync)
  );

  // Interrupt taken at an instruction boundary, abandoning that instruction
  assign take_irq = instr_valid && ie_reg && irq_sync;
  assign exec = instr_valid && !take_irq;
  assign is_reti = exec && (op_is(instr, OP_RETI_EN) || op_is(instr, OP_RETI_DIS));
  assign is_jump = exec && op_is(instr, OP_JUMP);
  assign overflow = take_irq && stk_full;
  assign underflow = is_reti && stk_empty;
  assign self_reset = overflow || underflow;
  assign stk_push = take_irq && !stk_full;
  assign stk_pop = is_reti && !stk_empty;
  assign stk_in = '{addr: pc_reg, carry: carry_reg, zero: zero_reg, bank: bank_reg};

  return_stack #(
    .LEVELS(LEVELS),
    .PTR_W(PTR_W)
  ) u_stack (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(self_reset),
    .push(stk_push),
    .pop(stk_pop),
    .push_data(stk_in),
    .top_data(stk_top),
    .full(stk_full),
    .empty(stk_empty),
    .depth(stk_depth)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next-state selection

  assign pc_next = self_reset ? PC_RESET :
                   take_irq ? vector_reg :
                   stk_pop ? stk_top.addr :
                   is_jump ? instr.target :
                   exec ? pc_reg + ADDR_W'(1) : pc_reg;

  assign ie_next = self_reset ? 1'b0 :
                   take_irq ? 1'b0 :
                   (exec && op_is(instr, OP_RETI_EN)) ? 1'b1 :
                   (exec && op_is(instr, OP_RETI_DIS)) ? 1'b0 :
                   (exec && op_is(instr, OP_INT_EN)) ? 1'b1 :
                   (exec && op_is(instr, OP_INT_DIS)) ? 1'b0 : ie_reg;

  assign carry_next = self_reset ? 1'b0 :
                      stk_pop ? stk_top.carry :
                      (exec && op_is(instr, OP_OTHER) && flag_update) ? carry_result : carry_reg;

  assign zero_next = self_reset ? 1'b0 :
                     stk_pop ? stk_top.zero :
                     (exec && op_is(instr, OP_OTHER) && flag_update) ? zero_result : zero_reg;

  assign bank_next = self_reset ? 1'b0 :
                     stk_pop ? stk_top.bank :
                     (exec && op_is(instr, OP_BANK_A)) ? 1'b0 :
                     (exec && op_is(instr, OP_BANK_B)) ? 1'b1 : bank_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pc_reg <= PC_RESET;
      ie_reg <= 1'b0;
      carry_reg <= 1'b0;
      zero_reg <= 1'b0;
      bank_reg <= 1'b0;
      ack_reg <= 1'b0;
      self_rst_reg <= 1'b0;
    end else begin
      pc_reg <= pc_next;
      ie_reg <= ie_next;
      carry_reg <= carry_next;
      zero_reg <= zero_next;
      bank_reg <= bank_next;
      ack_reg <= stk_push;
      self_rst_reg <= self_reset;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave

  logic apb_setup;
  logic apb_done;
  logic apb_wr;
  logic sel_vector;
  logic sel_status;
  logic sel_resets;
  logic mapped;
  logic clear_resets;
  logic [31:0] status_word;
  logic [31:0] resets_word;
  logic [31:0] read_mux;

  assign apb_setup = apb_req.psel && !apb_req.penable;
  assign apb_done = apb_req.psel && apb_req.penable && pready_reg;
  assign apb_wr = apb_done && apb_req.pwrite;
  assign sel_vector = (apb_req.paddr == OFS_VECTOR);
  assign sel_status = (apb_req.paddr == OFS_STATUS);
  assign sel_resets = (apb_req.paddr == OFS_RESETS);
  assign mapped = sel_vector || sel_status || sel_resets;
  assign clear_resets = apb_wr && sel_resets;

  assign status_word = {11'h000, bank_reg, zero_reg, carry_reg, ie_reg, stk_depth, pc_reg};
  assign resets_word = {14'h0000, unf_seen_reg, ovf_seen_reg, rst_count_reg};
  assign read_mux = sel_vector ? {20'h00000, vector_reg} :
                    sel_status ? status_word :
                    sel_resets ? resets_word : 32'h00000000;

  assign prdata_next = apb_setup ? ((apb_req.pwrite || !mapped) ? 32'h00000000 : read_mux) : prdata_reg;
  assign vector_next = (apb_wr && sel_vector) ? apb_req.pwdata[ADDR_W-1:0] : vector_reg;

  // Self-reset events win over a clear in the same cycle
  assign rst_count_next = self_reset ? (clear_resets ? COUNT_W'(1) : rst_count_reg + COUNT_W'(1)) :
                          clear_resets ? '0 : rst_count_reg;
  assign ovf_seen_next = overflow || (ovf_seen_reg && !clear_resets);
  assign unf_seen_next = underflow || (unf_seen_reg && !clear_resets);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      vector_reg <= VECTOR_RESET;
      rst_count_reg <= '0;
      ovf_seen_reg <= 1'b0;
      unf_seen_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= apb_setup;
      pslverr_reg <= apb_setup && !mapped;
      vector_reg <= vector_next;
      rst_count_reg <= rst_count_next;
      ovf_seen_reg <= ovf_seen_next;
      unf_seen_reg <= unf_seen_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign program_counter = pc_reg;
  assign interrupt_enable_flag = ie_reg;
  assign carry_flag = carry_reg;
  assign zero_flag = zero_reg;
  assign bank_select = bank_reg;
  assign interrupt_ack = ack_reg;
  assign internal_reset = self_rst_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_depth_limit;
    stk_depth <= PTR_W'(LEVELS);
  endproperty
  a_depth_limit: assert property (p_depth_limit) else $error("return stack deeper than its limit");

  property p_irq_push;
    (take_irq && !stk_full) |=> (stk_depth == $past(stk_depth) + PTR_W'(1)) && interrupt_ack
                                && (pc_reg == $past(vector_reg)) && !ie_reg;
  endproperty
  a_irq_push: assert property (p_irq_push) else $error("accepted interrupt did not push and vector");

  property p_overflow_reset;
    (take_irq && stk_full) |=> internal_reset && (pc_reg == PC_RESET) && (stk_depth == '0) && !ie_reg;
  endproperty
  a_overflow_reset: assert property (p_overflow_reset) else $error("overflow did not self-reset");

  property p_underflow_reset;
    (is_reti && stk_empty) |=> internal_reset && (pc_reg == PC_RESET) && !carry_reg && !bank_reg;
  endproperty
  a_underflow_reset: assert property (p_underflow_reset) else $error("underflow did not self-reset");

  property p_reti_enable;
    (stk_pop && op_is(instr, OP_RETI_EN)) |=> ie_reg;
  endproperty
  a_reti_enable: assert property (p_reti_enable) else $error("enabling return left interrupts off");

  property p_reti_masked;
    (stk_pop && op_is(instr, OP_RETI_DIS)) |=> !ie_reg ##1 !interrupt_ack;
  endproperty
  a_reti_masked: assert property (p_reti_masked) else $error("masked return enabled interrupts");

  property p_reti_restore;
    stk_pop |=> (bank_reg == $past(stk_top.bank)) && (pc_reg == $past(stk_top.addr))
                && (carry_reg == $past(stk_top.carry)) && (zero_reg == $past(stk_top.zero));
  endproperty
  a_reti_restore: assert property (p_reti_restore) else $error("return did not restore saved state");

  property p_jump_target;
    is_jump && !self_reset |=> pc_reg == $past(instr.target);
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("jump missed its target");

  property p_jump_keeps_state;
    is_jump |=> $stable(carry_reg) && $stable(zero_reg) && $stable(bank_reg) && $stable(ie_reg)
                && $stable(stk_depth);
  endproperty
  a_jump_keeps_state: assert property (p_jump_keeps_state) else $error("jump changed other state");

  property p_increment;
    (exec && op_is(instr, OP_OTHER)) |=> pc_reg == $past(pc_reg) + ADDR_W'(1);
  endproperty
  a_increment: assert property (p_increment) else $error("program counter did not advance");

  property p_self_jump_hold;
    (is_jump && instr.target == pc_reg) |=> $stable(pc_reg);
  endproperty
  a_self_jump_hold: assert property (p_self_jump_hold) else $error("self jump moved the counter");

  property p_reset_masks;
    internal_reset |-> !ie_reg && (pc_reg == PC_RESET);
  endproperty
  a_reset_masks: assert property (p_reset_masks) else $error("interrupts on after self-reset");

  property p_apb_answer;
    apb_setup |=> pready && (pslverr == !$past(mapped));
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("register access not answered next cycle");

  c_irq_taken: cover property (take_irq && !stk_full ##[1:20] stk_pop);
  c_overflow: cover property (take_irq && stk_full);
  c_underflow: cover property (is_reti && stk_empty);
  c_self_jump: cover property (is_jump && instr.target == pc_reg ##1 is_jump);

endmodule
`default_nettype wire

// ---- tb/prog_mem_model.sv ----
/*
  Program memory and interrupt source seen by the sequencer.
  Assumes the bench loads words into mem and steers irq_cmd.
*/
`timescale 1ns/1ns
`default_nettype none
module prog_mem_model (
  input wire logic [seq_pkg::ADDR_W-1:0] program_counter,
  input wire logic irq_cmd,
  output seq_pkg::instr_s instr,
  output logic interrupt_request
);
  import seq_pkg::*;
  instr_s mem [0:1023];
  // Smallest 1K memory; upper addresses alias down
  assign instr = mem[program_counter[9:0]];
  assign interrupt_request = irq_cmd;
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = '{OP_OTHER, 12'h000};
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
/*
  Self-checking bench of the program sequencer: APB master, program
  memory model, jump, interrupt, return and stack self-reset scenarios.
  Assumes seq_pkg and the design files are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import seq_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  apb_req_s apb_req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic instr_valid = 1'b0;
  instr_s instr;
  logic flag_update = 1'b1;
  logic carry_result = 1'b0;
  logic zero_result = 1'b0;
  logic irq_cmd = 1'b0;
  logic interrupt_request;
  logic [ADDR_W-1:0] program_counter;
  logic interrupt_enable_flag;
  logic carry_flag;
  logic zero_flag;
  logic bank_select;
  logic interrupt_ack;
  logic internal_reset;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] q;
  logic e;

  program_sequencer u_dut (.ref_clk(ref_clk), .rst(rst), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid), .instr(instr),
    .flag_update(flag_update), .carry_result(carry_result), .zero_result(zero_result),
    .interrupt_request(interrupt_request), .program_counter(program_counter),
    .interrupt_enable_flag(interrupt_enable_flag), .carry_flag(carry_flag), .zero_flag(zero_flag),
    .bank_select(bank_select), .interrupt_ack(interrupt_ack), .internal_reset(internal_reset));
  prog_mem_model u_mem (.program_counter(program_counter), .irq_cmd(irq_cmd), .instr(instr),
    .interrupt_request(interrupt_request));

  always #2 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One APB transfer, entered and left on a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    apb_req <= '0;
    @(posedge ref_clk);
  endtask

  task automatic run(input int n);
    instr_valid <= 1'b1;
    repeat (n) @(posedge ref_clk);
    instr_valid <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic flags(input logic c, input logic z, input logic b, input logic ie, input string msg);
    chk({28'h0, carry_flag, zero_flag, bank_select, interrupt_enable_flag}, {28'h0, c, z, b, ie}, msg);
  endtask

  // Runs until an accepted interrupt is acknowledged
  task automatic take_irq;
    int n;
    n = 0;
    irq_cmd <= 1'b1;
    instr_valid <= 1'b1;
    @(posedge ref_clk);
    while (interrupt_ack !== 1'b1 && n < 10) begin
      @(posedge ref_clk);
      n++;
    end
    chk({20'h0, program_counter}, 32'h100, "vector load");
    instr_valid <= 1'b0;
    irq_cmd <= 1'b0;
    @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_start;
    chk({20'h0, program_counter}, 32'h0, "start address");
    chk({31'h0, interrupt_enable_flag}, 32'h0, "ie after reset");
    u_mem.mem[1] = '{OP_INT_EN, 12'h000};
    u_mem.mem[2] = '{OP_INT_DIS, 12'h000};
    run(4);
    chk({20'h0, program_counter}, 32'h4, "increment");
    chk({31'h0, interrupt_enable_flag}, 32'h0, "ie disabled");
  endtask

  task automatic t_regs;
    apb(1'b0, OFS_VECTOR, 32'h0);
    chk(q, 32'h3FF, "vector reset");
    apb(1'b1, OFS_VECTOR, 32'h100);
    apb(1'b0, OFS_VECTOR, 32'h0);
    chk(q, 32'h100, "vector rw");
    chk({31'h0, e}, 32'h0, "no error on mapped");
    apb(1'b1, OFS_STATUS, 32'hFFF);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h4, "status read only");
    apb(1'b0, 12'h00C, 32'h0);
    chk({e, q[30:0]}, 32'h8000_0000, "unmapped");
  endtask

  task automatic t_jump;
    u_mem.mem[5] = '{OP_JUMP, 12'hFFF};
    u_mem.mem[1023] = '{OP_JUMP, 12'h007};
    u_mem.mem[7] = '{OP_JUMP, 12'h007};
    carry_result <= 1'b1;
    zero_result <= 1'b1;
    run(1);
    carry_result <= 1'b0;
    zero_result <= 1'b0;
    run(1);
    chk({20'h0, program_counter}, 32'hFFF, "jump top address");
    flags(1'b1, 1'b1, 1'b0, 1'b0, "jump keeps flags");
    run(1);
    run(8);
    chk({20'h0, program_counter}, 32'h7, "self jump hold");
  endtask

  task automatic t_irq;
    u_mem.mem[7] = '{OP_INT_EN, 12'h000};
    u_mem.mem[8] = '{OP_BANK_B, 12'h000};
    u_mem.mem[10] = '{OP_JUMP, 12'h00A};
    u_mem.mem[256] = '{OP_BANK_A, 12'h000};
    u_mem.mem[258] = '{OP_RETI_EN, 12'h000};
    carry_result <= 1'b1;
    run(4);
    take_irq();
    flags(1'b1, 1'b0, 1'b0, 1'b0, "entry");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h0004_1101, "status in routine");
    carry_result <= 1'b0;
    zero_result <= 1'b1;
    run(2);
    chk({20'h0, program_counter}, 32'hA, "resume");
    flags(1'b1, 1'b0, 1'b1, 1'b1, "enabling return");
    u_mem.mem[258] = '{OP_RETI_DIS, 12'h000};
    take_irq();
    run(2);
    flags(1'b1, 1'b0, 1'b1, 1'b0, "masked return");
    irq_cmd <= 1'b1;
    run(8);
    irq_cmd <= 1'b0;
    chk({20'h0, program_counter}, 32'hA, "request ignored");
  endtask

  task automatic t_underflow;
    u_mem.mem[10] = '{OP_RETI_EN, 12'h000};
    instr_valid <= 1'b1;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    @(posedge ref_clk);
    chk({19'h0, internal_reset, program_counter}, 32'h1000, "underflow reset");
    apb(1'b0, OFS_RESETS, 32'h0);
    chk(q, 32'h0002_0001, "underflow record");
  endtask

  task automatic t_overflow;
    int k;
    int n;
    k = 0;
    n = 0;
    u_mem.mem[2] = '{OP_JUMP, 12'h002};
    u_mem.mem[256] = '{OP_INT_EN, 12'h000};
    u_mem.mem[257] = '{OP_JUMP, 12'h101};
    irq_cmd <= 1'b1;
    instr_valid <= 1'b1;
    while (k < 30 && n < 200) begin
      @(posedge ref_clk);
      n++;
      k += (interrupt_ack === 1'b1);
    end
    instr_valid <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({27'h0, q[16:12]}, 32'h1E, "thirty levels");
    n = 0;
    instr_valid <= 1'b1;
    @(posedge ref_clk);
    while (internal_reset !== 1'b1 && n < 10) begin
      k += (interrupt_ack === 1'b1);
      @(posedge ref_clk);
      n++;
    end
    chk({19'h0, internal_reset, program_counter}, 32'h1000, "overflow reset");
    chk(k, 32'h1E, "no 31st level");
    instr_valid <= 1'b0;
    irq_cmd <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, OFS_RESETS, 32'h0);
    chk(q, 32'h0003_0002, "overflow record");
    apb(1'b1, OFS_RESETS, 32'h0);
    apb(1'b0, OFS_RESETS, 32'h0);
    chk(q, 32'h0, "record cleared");
  endtask

  // Reset in mid-run breaks a self jump; request pin held high throughout
  task automatic t_reset;
    u_mem.mem[1] = '{OP_JUMP, 12'h001};
    irq_cmd <= 1'b1;
    instr_valid <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk({19'h0, interrupt_enable_flag, program_counter}, 32'h0, "mid-run reset");
    repeat (6) @(posedge ref_clk);
    instr_valid <= 1'b0;
    irq_cmd <= 1'b0;
    chk({19'h0, interrupt_ack, program_counter}, 32'h1, "request ignored after reset");
    @(posedge ref_clk);
    apb(1'b0, OFS_VECTOR, 32'h0);
    chk(q, 32'h3FF, "vector after reset");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_start();
    t_regs();
    t_jump();
    t_irq();
    t_underflow();
    t_overflow();
    t_reset();
    finish_test();
  end
endmodule
`default_nettype wire
